// ===== stm_defines.vh
/*
  Constants for the standard timer pulse/capture block: register offsets,
  field positions, mode and pin function codes, reset values.
  Assumes it is included by bare name from every design file that needs it.
*/
`ifndef STM_DEFINES_VH
`define STM_DEFINES_VH

`define STM_OFF_CTRL0     12'h000
`define STM_OFF_CTRL1     12'h004
`define STM_OFF_CNTLO     12'h008
`define STM_OFF_CNTHI     12'h00C
`define STM_OFF_CCRALO    12'h010
`define STM_OFF_CCRAHI    12'h014
`define STM_OFF_CCRPLO    12'h018
`define STM_OFF_CCRPHI    12'h01C
`define STM_OFF_STATUS    12'h020

`define STM_CTRL0_RUN     3
`define STM_CTRL0_PAUSE   7
`define STM_CTRL1_MODE_HI 7
`define STM_CTRL1_MODE_LO 6
`define STM_CTRL1_PIN_HI  5
`define STM_CTRL1_PIN_LO  4
`define STM_CTRL1_OC      3
`define STM_CTRL1_POL     2
`define STM_CTRL1_DPX     1
`define STM_CTRL1_CCLR    0

`define STM_MODE_CMP      2'h0
`define STM_MODE_CAPT     2'h1
`define STM_MODE_PULSE    2'h2
`define STM_MODE_TIMER    2'h3

`define STM_PIN_RISE      2'h0
`define STM_PIN_FALL      2'h1
`define STM_PIN_BOTH      2'h2
`define STM_PIN_OFF       2'h3
`define STM_PIN_SINGLE    2'h3

`define STM_CNT_W         10
`define STM_CNT_MAX       10'h3FF
`define STM_RESET_BYTE    8'h00
`endif

// ===== stm_edge_sync.v
/*
  Two-flop synchroniser with a third stage for edge detection.
  Assumes the input is asynchronous to mclk.
*/
`include "stm_defines.vh"

module stm_edge_sync (
  input  wire mclk,
  input  wire reset_n,
  input  wire pinIn,
  output reg  riseSeen,
  output reg  fallSeen
);
  reg meta_reg;
  reg sync_reg;
  reg last_reg;

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
      riseSeen <= 1'b0;
      fallSeen <= 1'b0;
    end else begin
      meta_reg <= pinIn;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
      riseSeen <= sync_reg & ~last_reg;
      fallSeen <= ~sync_reg & last_reg;
    end
  end
endmodule

// ===== stm_pulse_capture.v
/*
  Standard timer, single pulse output and capture input modes, APB slave.
  Assumes an APB master on mclk; trigger and capture pins are asynchronous.
*/
`include "stm_defines.vh"

module stm_pulse_capture (
  input  wire        mclk,
  input  wire        reset_n,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        extTriggerPin,
  input  wire        captureInputPin,
  output reg         timerOut,
  output reg         timerOutEn,
  output reg         timerIrq
);
  localparam ST_IDLE = 2'h0;
  localparam ST_RUN  = 2'h1;
  localparam ST_DONE = 2'h2;

  reg  [7:0]  ctrl0_reg;
  reg  [7:0]  ctrl1_reg;
  reg  [9:0]  compare_a_value_reg;
  reg  [9:0]  compare_p_value_reg;
  reg  [9:0]  count_reg;
  reg         runPrev_reg;
  reg  [1:0]  state_reg;
  reg  [1:0]  state_next;
  reg  [2:0]  evSticky_reg;

  wire        trigRise;
  wire        captRise;
  wire        captFall;

  wire        runBit     = ctrl0_reg[`STM_CTRL0_RUN];
  wire        pauseBit   = ctrl0_reg[`STM_CTRL0_PAUSE];
  wire [1:0]  modeSel    = {ctrl1_reg[`STM_CTRL1_MODE_HI],
                            ctrl1_reg[`STM_CTRL1_MODE_LO]};
  wire [1:0]  pinFunc    = {ctrl1_reg[`STM_CTRL1_PIN_HI],
                            ctrl1_reg[`STM_CTRL1_PIN_LO]};
  wire        outActive  = ctrl1_reg[`STM_CTRL1_OC];
  wire        outInvert  = ctrl1_reg[`STM_CTRL1_POL];
  wire        isPulse    = (modeSel == `STM_MODE_PULSE) &&
                           (pinFunc == `STM_PIN_SINGLE);
  wire        isCapt     = (modeSel == `STM_MODE_CAPT);

  // Writes commit only on the edge that completes the transfer; a write in
  // the wait cycle as well could re-arm run after compare A cleared it
  wire        apbWrite   = psel & penable & pwrite & pready;
  wire        apbRead    = psel & penable & ~pwrite;

  // Decode an address to a one-hot word; used by write and read paths
  function [8:0] regHit;
    input [11:0] addr;
    begin
      regHit = 9'h000;
      case (addr)
        `STM_OFF_CTRL0:  regHit[0] = 1'b1;
        `STM_OFF_CTRL1:  regHit[1] = 1'b1;
        `STM_OFF_CNTLO:  regHit[2] = 1'b1;
        `STM_OFF_CNTHI:  regHit[3] = 1'b1;
        `STM_OFF_CCRALO: regHit[4] = 1'b1;
        `STM_OFF_CCRAHI: regHit[5] = 1'b1;
        `STM_OFF_CCRPLO: regHit[6] = 1'b1;
        `STM_OFF_CCRPHI: regHit[7] = 1'b1;
        `STM_OFF_STATUS: regHit[8] = 1'b1;
        default:         regHit = 9'h000;
      endcase
    end
  endfunction

  wire [8:0]  hit        = regHit(paddr);
  wire        mapped     = |hit;
  // One write strobe per writable register, live only on the completing edge
  wire        wrCtrl1    = apbWrite & hit[1];
  wire        wrCcraLo   = apbWrite & hit[4];
  wire        wrCcraHi   = apbWrite & hit[5];
  wire        wrCcrpLo   = apbWrite & hit[6];
  wire        wrCcrpHi   = apbWrite & hit[7];
  wire        wrStatus   = apbWrite & hit[8];

  // A pin change acts about four clocks later; levels shorter than one
  // clock may be missed, so short pulses are the user's responsibility
  stm_edge_sync trigSync (
    .mclk     (mclk),
    .reset_n  (reset_n),
    .pinIn    (extTriggerPin),
    .riseSeen (trigRise),
    .fallSeen ()
  );

  stm_edge_sync captSync (
    .mclk     (mclk),
    .reset_n  (reset_n),
    .pinIn    (captureInputPin),
    .riseSeen (captRise),
    .fallSeen (captFall)
  );

  reg captEdge;
  always @* begin
    case (pinFunc)
      `STM_PIN_RISE: captEdge = captRise;
      `STM_PIN_FALL: captEdge = captFall;
      `STM_PIN_BOTH: captEdge = captRise | captFall;
      default:       captEdge = 1'b0;
    endcase
  end

  wire        captHit    = isCapt & runBit & captEdge &
                           (pinFunc != `STM_PIN_OFF);
  wire        runRise    = runBit & ~runPrev_reg;
  // The run rise cycle only clears; counting starts one clock later
  wire        counting   = runBit & ~pauseBit & ~runRise;
  // Compare A only acts in single pulse mode; capture reuses the register
  wire        cmpAHit    = isPulse & counting & (count_reg == compare_a_value_reg);
  // zero compare P wraps at full count
  wire        cmpPHit    = isCapt & counting &
                           (((compare_p_value_reg != 10'h000) &&
                             (count_reg == compare_p_value_reg)) ||
                            ((compare_p_value_reg == 10'h000) &&
                             (count_reg == `STM_CNT_MAX)));
  wire        trigStart  = isPulse & ~runBit & trigRise;
  wire        swRunWr    = apbWrite & hit[0];

  // Control register 0 holds run; hardware set and clear share it
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl0_reg <= `STM_RESET_BYTE;
    end else begin
      if (swRunWr) begin
        ctrl0_reg <= {pwdata[7:3], 3'h0};
      end
      if (cmpAHit) begin
        ctrl0_reg[`STM_CTRL0_RUN] <= 1'b0;
      end
      if (trigStart) begin
        ctrl0_reg[`STM_CTRL0_RUN] <= 1'b1;
      end
    end
  end

  // Mode and pin function; change them only while run is low
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl1_reg <= `STM_RESET_BYTE;
    end else if (wrCtrl1) begin
      ctrl1_reg <= pwdata[7:0];
    end
  end

  // Compare P bytes land independently; no shadowing between the halves
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      compare_p_value_reg <= 10'h000;
    end else begin
      if (wrCcrpLo) begin
        compare_p_value_reg[7:0] <= pwdata[7:0];
      end
      if (wrCcrpHi) begin
        compare_p_value_reg[9:8] <= pwdata[1:0];
      end
    end
  end

  // capture latches counter into compare A, winning over a write
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      compare_a_value_reg <= 10'h000;
    end else if (captHit) begin
      compare_a_value_reg <= count_reg;
    end else if (wrCcraLo) begin
      compare_a_value_reg[7:0] <= pwdata[7:0];
    end else if (wrCcraHi) begin
      compare_a_value_reg[9:8] <= pwdata[1:0];
    end
  end

  // Counter: cleared on run rise, wraps on compare P in capture mode
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      count_reg   <= 10'h000;
      runPrev_reg <= 1'b0;
    end else begin
      runPrev_reg <= runBit;
      if (runRise) begin
        count_reg <= 10'h000;
      end else if (cmpPHit) begin
        count_reg <= 10'h000;
      // count only while run high; a compare A match parks the
      // counter on the match value, so software reads back the width
      end else if (counting & ~cmpAHit) begin
        count_reg <= count_reg + 10'h001;
      end
    end
  end

  // Pulse sequencer
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (isPulse & runRise) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (~runBit | ~isPulse) begin
          state_next = ST_DONE;
        end
      end
      ST_DONE: begin
        if (isPulse & runRise) begin
          state_next = ST_RUN;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // pulse uses neither compare P nor clear or swap bits
  wire pulseLevel = (state_next == ST_RUN) ? outActive : ~outActive;

  // output follows sequencer; no drive in capture mode
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      timerOut   <= 1'b0;
      timerOutEn <= 1'b0;
    end else begin
      timerOutEn <= isPulse;
      timerOut   <= isPulse ? (pulseLevel ^ outInvert) : 1'b0;
    end
  end

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      timerIrq <= 1'b0;
    end else begin
      timerIrq <= cmpAHit | captHit | cmpPHit;
    end
  end

  // Event record for software; a new event wins over a clear
  wire [2:0] evNow = {cmpPHit, captHit, cmpAHit};
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      evSticky_reg <= 3'h0;
    end else if (wrStatus) begin
      evSticky_reg <= (evSticky_reg & ~pwdata[2:0]) | evNow;
    end else begin
      evSticky_reg <= evSticky_reg | evNow;
    end
  end

  reg [31:0] readMux;
  always @* begin
    readMux = 32'h0000_0000;
    case (1'b1)
      hit[0]: readMux[7:0] = ctrl0_reg;
      hit[1]: readMux[7:0] = ctrl1_reg;
      hit[2]: readMux[7:0] = count_reg[7:0];
      hit[3]: readMux[1:0] = count_reg[9:8];
      hit[4]: readMux[7:0] = compare_a_value_reg[7:0];
      hit[5]: readMux[1:0] = compare_a_value_reg[9:8];
      hit[6]: readMux[7:0] = compare_p_value_reg[7:0];
      hit[7]: readMux[1:0] = compare_p_value_reg[9:8];
      hit[8]: readMux[3:0] = {runBit, evSticky_reg};
      default: readMux = 32'h0000_0000;
    endcase
  end

  // One wait state: ready rises in the second access cycle
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pready <= 1'b0;
    end else begin
      pready <= psel & penable & ~pready;
    end
  end

  // Unmapped offsets answer with an error in the ready cycle
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= psel & penable & ~pready & ~mapped;
    end
  end

  // Read data stands only in the ready cycle and is zero otherwise
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= 32'h0000_0000;
    end else begin
      prdata <= (apbRead & ~pready) ? readMux : 32'h0000_0000;
    end
  end
endmodule

// ===== stm_pulse_capture_properties.sv
/* Port checker for stm_pulse_capture.
   Assumes one mclk domain; bound from tb_top. */
module stm_pulse_capture_properties (
  input logic        mclk,
  input logic        reset_n,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [11:0] paddr,
  input logic [31:0] prdata,
  input logic        pready,
  input logic        pslverr,
  input logic        timerOut,
  input logic        timerOutEn,
  input logic        timerIrq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held");
  chk_ready_late: assert property
    (psel && !penable ##1 psel && penable |=> pready)
    else $error("ready late");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  chk_hi_byte: assert property
    (pready && !pwrite && paddr == 12'h00C |-> prdata[31:2] == 30'h0)
    else $error("counter high byte too wide");
  chk_no_output: assert property (!timerOutEn |-> !timerOut)
    else $error("output outside pulse mode");
  chk_irq_single: assert property
    (timerOutEn && timerIrq |=> !timerIrq)
    else $error("pulse interrupt held");
  chk_out_after: assert property
    (timerOutEn && timerIrq |-> ##3 $stable(timerOut) [*4])
    else $error("output moved after pulse");
  chk_mode_write: assert property
    ($rose(timerOutEn) |-> $past(psel && penable && pwrite && pready, 2))
    else $error("pulse mode without write");
endmodule

// ===== stm_pin_driver.sv
/* Model of the trigger and capture pins.
   Assumes calls start just after an mclk edge. */
module stm_pin_driver (
  input  logic mclk,
  output logic extTriggerPin,
  output logic captureInputPin
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    extTriggerPin = 1'b0;
    captureInputPin = 1'b0;
  end
  // rising trigger, held past the synchroniser
  task automatic fireTrigger();
    @(posedge mclk);
    extTriggerPin <= 1'b1;
    repeat (3) @(posedge mclk);
    extTriggerPin <= 1'b0;
  endtask
  // level held long enough to be seen once
  task automatic moveCapture(input logic lvl);
    @(posedge mclk);
    captureInputPin <= lvl;
    repeat (5) @(posedge mclk);
  endtask
endmodule

// ===== tb_top.sv
/* Self-checking bench for stm_pulse_capture.
   Assumes the pin model and the bound port checker. */
`include "stm_defines.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk, reset_n, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic        extTriggerPin, captureInputPin;
  logic        timerOut, timerOutEn, timerIrq;
  logic [64:0] expQ[$];
  logic [64:0] note;
  int          errors, nTests, seed, w, pf, c1;
  stm_pulse_capture u_dut (.mclk(mclk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .extTriggerPin(extTriggerPin), .captureInputPin(captureInputPin),
    .timerOut(timerOut), .timerOutEn(timerOutEn), .timerIrq(timerIrq));
  stm_pin_driver u_pins (.mclk(mclk), .extTriggerPin(extTriggerPin),
    .captureInputPin(captureInputPin));
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    nTests++;
    if (seen !== exp) begin
      errors++;
      $display("Error %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic testDone();
    $display("errors %0d checks %0d", errors, nTests);
    if (errors == 0 && nTests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic hang(input int k);
    if (k >= 3000) begin
      errors++;
      testDone();
    end
  endtask
  task automatic xfer(input logic [11:0] a, input logic wr,
                      input logic [31:0] d);
    int k;
    k = 0;
    psel   <= 1'b1;
    paddr  <= a;
    pwrite <= wr;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      k++;
    end while (pready !== 1'b1 && k < 3000);
    rv = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
    hang(k);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e,
                    input logic [31:0] m, input logic er);
    expQ.push_back({er, m, e & m});
    xfer(a, 1'b0, 32'h0);
  endtask
  task automatic waitPulse();
    int k;
    int hi;
    k = 0;
    hi = 0;
    while (timerIrq !== 1'b1 && k < 3000) begin
      @(posedge mclk);
      k++;
      hi += int'(timerOut === 1'b1);
    end
    hang(k);
    check(33'(hi + 3 >= w && hi <= w + 3), 33'h1);
  endtask
  always @(posedge mclk) begin
    if (pready === 1'b1 && pwrite === 1'b0 && expQ.size() > 0) begin
      note = expQ.pop_front();
      check({pslverr, prdata & note[63:32]}, {note[64], note[31:0]});
    end
  end
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  initial begin
    {reset_n, psel, penable, pwrite} = 4'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    errors = 0;
    nTests = 0;
    seed = 54;
    repeat (5) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    for (int i = 0; i < 9; i++)
      rd(12'(i * 4), 32'h0, 32'hFFFFFFFF, 1'b0);
    rd(12'h3FC, 32'h0, 32'hFFFFFFFF, 1'b1);
    w = 8 + ($random(seed) & 15);
    // Swap, clear select and a small compare P must all be ignored
    xfer(`STM_OFF_CTRL1, 1'b1, 32'hBB);
    xfer(`STM_OFF_CCRALO, 1'b1, 32'(w));
    xfer(`STM_OFF_CCRPLO, 1'b1, 32'h3);
    check({31'h0, timerOutEn, timerOut}, 33'h2);
    xfer(`STM_OFF_CTRL0, 1'b1, 32'h8);
    waitPulse();
    repeat (20) @(posedge mclk);
    rd(`STM_OFF_CNTLO, 32'(w), 32'hFF, 1'b0);
    rd(`STM_OFF_STATUS, 32'h1, 32'hF, 1'b0);
    xfer(`STM_OFF_STATUS, 1'b1, 32'h7);
    fork
      u_pins.fireTrigger();
    join_none
    waitPulse();
    rd(`STM_OFF_CNTLO, 32'(w), 32'hFF, 1'b0);
    xfer(`STM_OFF_STATUS, 1'b1, 32'h7);
    xfer(`STM_OFF_CCRAHI, 1'b1, 32'h3);
    xfer(`STM_OFF_CTRL0, 1'b1, 32'h8);
    xfer(`STM_OFF_CTRL0, 1'b1, 32'h0);
    repeat (2) @(posedge mclk);
    check({32'h0, timerOut}, 33'h0);
    rd(`STM_OFF_CNTLO, 32'h0, 32'h0, 1'b0);
    c1 = rv;
    repeat (10) @(posedge mclk);
    rd(`STM_OFF_CNTLO, c1, 32'hFF, 1'b0);
    xfer(`STM_OFF_CCRPLO, 1'b1, 32'h0);
    for (pf = 0; pf < 4; pf++) begin
      xfer(`STM_OFF_CCRALO, 1'b1, 32'hFF);
      xfer(`STM_OFF_CTRL1, 1'b1, 32'h4C | (pf << 4));
      xfer(`STM_OFF_CTRL0, 1'b1, 32'h8);
      xfer(`STM_OFF_STATUS, 1'b1, 32'h7);
      rd(`STM_OFF_CNTLO, 32'h0, 32'h0, 1'b0);
      c1 = rv;
      u_pins.moveCapture(1'b1);
      rd(`STM_OFF_STATUS, 32'(!pf[0]) << 1, 32'h2, 1'b0);
      rd(`STM_OFF_CCRALO, 32'h0, 32'h0, 1'b0);
      if (!pf[0])
        check(33'(rv - c1 < 24), 33'h1);
      else
        check(33'(rv), 33'hFF);
      check({31'h0, timerOutEn, timerOut}, 33'h0);
      xfer(`STM_OFF_STATUS, 1'b1, 32'h7);
      u_pins.moveCapture(1'b0);
      rd(`STM_OFF_STATUS, 32'(pf[0] ^ pf[1]) << 1, 32'h2, 1'b0);
      rd(`STM_OFF_CNTLO, 32'h0, 32'h0, 1'b0);
      check(33'(rv > c1), 33'h1);
      xfer(`STM_OFF_CTRL0, 1'b1, 32'h0);
    end
    xfer(`STM_OFF_CTRL1, 1'b1, 32'h40);
    xfer(`STM_OFF_CCRPLO, 1'b1, 32'h28);
    xfer(`STM_OFF_STATUS, 1'b1, 32'h7);
    xfer(`STM_OFF_CTRL0, 1'b1, 32'h8);
    repeat (60) @(posedge mclk);
    rd(`STM_OFF_STATUS, 32'hC, 32'hC, 1'b0);
    rd(`STM_OFF_CNTLO, 32'h0, 32'h0, 1'b0);
    check(33'(rv <= 32'h28), 33'h1);
    xfer(`STM_OFF_CTRL0, 1'b1, 32'h0);
    xfer(`STM_OFF_CCRPLO, 1'b1, 32'h0);
    xfer(`STM_OFF_STATUS, 1'b1, 32'h7);
    xfer(`STM_OFF_CTRL0, 1'b1, 32'h8);
    repeat (900) @(posedge mclk);
    rd(`STM_OFF_STATUS, 32'h0, 32'h4, 1'b0);
    repeat (200) @(posedge mclk);
    rd(`STM_OFF_STATUS, 32'h4, 32'h4, 1'b0);
    testDone();
  end
endmodule
bind stm_pulse_capture stm_pulse_capture_properties u_chk (.mclk(mclk),
  .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .timerOut(timerOut), .timerOutEn(timerOutEn), .timerIrq(timerIrq));
